// file: common/lcsm_cfg.svh
// Constants for the loop coil and status-word map
// Functional notes
// - Each loop owns 48 consecutive coils starting at 296 + 48*(k-1).
// - Mode word bits 0-6: auto, local, standby, external, console, computer, ramping.
// - Mode word bits 7-15: override, emergency, hold, hi/lo limit, OOS, user 1/2, autotune.
// - Mode word status bits are read-only; the mode selections are host writable.
// - Alarm word: alarm n uses bits 3(n-1)..+2 as active, not-acked, enabled.
// - Alarm word bit 12 OOS, 13 config changed, 14 unacked event, 15 active event.
// - Coils 0-15 mirror mode word, 16-31 alarm word, 32-47 extended word.
// - Extended bits 0-6 are not-acked flags for standby through user status 2.
// - Extended bits 7-12 are not-acked flags for autotune W1-W3 and E1-E3.
// - Extended bit 13 is write-only; writing 1 transfers autotune parameters.
// - Extended bits 14 and 15 read the two push-button switch levels.
// - Writing 1 to a push-button bit acts as press and release of that button.
// - A sustained push-button toggles on a written press and keeps that position.
// - A momentary push-button closes for exactly one scan cycle, then reopens.
`ifndef LCSM_CFG_SVH
`define LCSM_CFG_SVH

// ----------------------------------------
// Coil map
// ----------------------------------------
`define LCSM_COIL_FIRST 16'h0128
`define LCSM_COIL_STRIDE 16'h0030
`define LCSM_COIL_COUNT 16'h0030

// ----------------------------------------
// Word map: {channel offset, parameter}
// ----------------------------------------
`define LCSM_ADDR_MODE 16'h0301
`define LCSM_ADDR_ALARM 16'h0401
`define LCSM_ADDR_EXT 16'h040A

// ----------------------------------------
// Writable bit masks and field positions
// ----------------------------------------
`define LCSM_MODE_WR_MASK 16'h907B
`define LCSM_ALARM_WR_MASK 16'h5DB6
`define LCSM_EXT_ACK_MASK 16'h1FFF
`define LCSM_OOS_BIT 12
`define LCSM_EXT_XFER_BIT 13
`define LCSM_EXT_PB1_BIT 14
`define LCSM_EXT_PB2_BIT 15
`define LCSM_ALARM_NA_BIT 14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCSM_WORD_RST 16'h0000

`endif

// file: common/lcsm_pkg.sv
// Types for the loop coil and status-word map
package lcsm_pkg;

	typedef logic [15:0] lcsm_word_t;

	typedef enum logic [1:0] {
		LCSM_PB_IDLE = 2'b00,
		LCSM_PB_ARMED = 2'b01,
		LCSM_PB_CLOSED = 2'b10
	} lcsm_pb_state_t;

	typedef enum logic [1:0] {
		LCSM_W_MODE = 2'b00,
		LCSM_W_ALARM = 2'b01,
		LCSM_W_EXT = 2'b10,
		LCSM_W_NONE = 2'b11
	} lcsm_wsel_t;

endpackage

// file: design/lcsm_rst_sync.sv
// Reset release synchroniser
`timescale 1ns/1ns
module lcsm_rst_sync (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	output logic rst_b_o
);
	logic meta_q;

	// Assert at once, release two edges later
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= 1'b0;
			rst_b_o <= 1'b0;
		end else begin
			meta_q <= 1'b1;
			rst_b_o <= meta_q;
		end
	end
endmodule // lcsm_rst_sync

// file: design/lcsm_pbsw.sv
// Push-button switch emulation for one faceplate button
`timescale 1ns/1ns
module lcsm_pbsw (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic press_i,
	input wire logic sustained_i,
	input wire logic scan_tick_i,
	output logic level_o
);
	import lcsm_pkg::*;

	lcsm_pb_state_t state_q;
	lcsm_pb_state_t state_d;
	logic level_d;

	always_comb begin
		state_d = state_q;
		level_d = level_o;
		case (state_q)
			LCSM_PB_IDLE: begin
				if (press_i && sustained_i) begin
					level_d = ~level_o;
				end else if (press_i) begin
					state_d = LCSM_PB_ARMED;
				end
			end
			// Wait for a scan boundary so the closure spans one full scan
			LCSM_PB_ARMED: begin
				if (scan_tick_i) begin
					state_d = LCSM_PB_CLOSED;
					level_d = 1'b1;
				end
			end
			LCSM_PB_CLOSED: begin
				if (scan_tick_i) begin
					state_d = LCSM_PB_IDLE;
					level_d = 1'b0;
				end
			end
			default: begin
				state_d = LCSM_PB_IDLE;
				level_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= LCSM_PB_IDLE;
			level_o <= 1'b0;
		end else begin
			state_q <= state_d;
			level_o <= level_d;
		end
	end
endmodule // lcsm_pbsw

// file: design/lcsm_loop_map.sv
// Coil and status-word map of one controller loop
`timescale 1ns/1ns
`include "lcsm_cfg.svh"
module lcsm_loop_map #(
	parameter logic [15:0] LOOP_NUM = 16'h0001
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Host access: coil number or {channel offset, parameter}
	input wire logic req_i,
	input wire logic req_we_i,
	input wire logic req_coil_i,
	input wire logic [15:0] req_addr_i,
	input wire lcsm_pkg::lcsm_word_t req_wdata_i,
	output logic rsp_valid_o,
	output logic rsp_err_o,
	output lcsm_pkg::lcsm_word_t rsp_rdata_o,
	// Read-only status from the function blocks
	input wire logic standby_i,
	input wire logic override_i,
	input wire logic emergency_manual_flag_i,
	input wire logic configuration_hold_flag_i,
	input wire logic high_setpoint_limit_flag_i,
	input wire logic low_setpoint_limit_flag_i,
	input wire logic user_status_one_i,
	input wire logic user_status_two_i,
	input wire logic [3:0] alarm_active_i,
	input wire logic configuration_changed_i,
	input wire logic active_loop_event_i,
	// Events that raise not-acknowledged flags
	input wire logic [3:0] alarm_event_i,
	input wire logic loop_event_i,
	input wire logic [12:0] ext_event_i,
	// Push-button configuration and controller scan boundary
	input wire logic [1:0] pb_sustained_i,
	input wire logic scan_tick_i,
	// Register-driven controls
	output lcsm_pkg::lcsm_word_t mode_ctrl_o,
	output lcsm_pkg::lcsm_word_t alarm_ctrl_o,
	output logic [12:0] ext_unack_o,
	output logic tuning_parameter_transfer_o,
	output logic pushbutton_switch_one_o,
	output logic pushbutton_switch_two_o
);
	import lcsm_pkg::*;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic lcsm_wsel_t word_of(input logic [15:0] a);
		if (a == `LCSM_ADDR_MODE) begin
			word_of = LCSM_W_MODE;
		end else if (a == `LCSM_ADDR_ALARM) begin
			word_of = LCSM_W_ALARM;
		end else if (a == `LCSM_ADDR_EXT) begin
			word_of = LCSM_W_EXT;
		end else begin
			word_of = LCSM_W_NONE;
		end
	endfunction

	logic rst_b;
	logic [15:0] coil_base;
	logic [15:0] coil_off;
	logic coil_hit;
	lcsm_wsel_t sel;
	logic [15:0] bit_mask;
	lcsm_word_t wr_val;
	logic wr_go;
	logic wr_mode;
	logic wr_alarm;
	logic wr_ext;

	lcsm_rst_sync u_rst_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.rst_b_o(rst_b)
	);

	assign coil_base = `LCSM_COIL_FIRST + 16'((LOOP_NUM - 16'h0001) * `LCSM_COIL_STRIDE);
	assign coil_off = req_addr_i - coil_base;
	assign coil_hit = (req_addr_i >= coil_base) && (coil_off < `LCSM_COIL_COUNT);
	// Coil offset bits 5:4 pick the word, 3:0 the bit
	assign sel = req_coil_i ? (coil_hit ? lcsm_wsel_t'(coil_off[5:4]) : LCSM_W_NONE)
		: word_of(req_addr_i);
	assign bit_mask = req_coil_i ? (16'h0001 << coil_off[3:0]) : 16'hFFFF;
	assign wr_val = req_coil_i ? {16{req_wdata_i[0]}} : req_wdata_i;
	assign wr_go = req_i && req_we_i;
	assign wr_mode = wr_go && (sel == LCSM_W_MODE);
	assign wr_alarm = wr_go && (sel == LCSM_W_ALARM);
	assign wr_ext = wr_go && (sel == LCSM_W_EXT);

	// ----------------------------------------
	// Writable storage
	// ----------------------------------------
	logic [15:0] mode_q;
	logic [15:0] mode_d;
	logic [15:0] alarm_q;
	logic [15:0] alarm_d;
	logic [12:0] ext_q;
	logic [12:0] ext_d;
	logic [15:0] mode_wm;
	logic [15:0] alarm_wm;
	logic [15:0] ext_wm;
	logic [15:0] alarm_set;
	logic oos_d;
	logic [15:0] mode_hold;
	logic [15:0] mode_new;
	logic [15:0] mode_next;

	assign mode_wm = wr_mode ? (bit_mask & `LCSM_MODE_WR_MASK) : 16'h0000;
	assign alarm_wm = wr_alarm ? (bit_mask & `LCSM_ALARM_WR_MASK) : 16'h0000;
	assign ext_wm = wr_ext ? bit_mask : 16'h0000;

	// Alarms out of service is one flag seen in both words
	assign oos_d = alarm_wm[`LCSM_OOS_BIT] ? wr_val[`LCSM_OOS_BIT]
		: (mode_wm[`LCSM_OOS_BIT] ? wr_val[`LCSM_OOS_BIT] : mode_q[`LCSM_OOS_BIT]);

	// Held value with the shared flag folded in at bit 12
	assign mode_hold = {mode_q[15:13], oos_d, mode_q[11:0]};
	assign mode_new = wr_val & mode_wm;
	assign mode_d = (mode_hold & ~mode_wm) | (mode_new & ~16'h1000)
		| {3'h0, oos_d, 12'h000};
	// Only writable bits are stored; status bits are merged in on read
	assign mode_next = mode_d & `LCSM_MODE_WR_MASK;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_alarm
			assign alarm_set[3 * g] = 1'b0;
			assign alarm_set[3 * g + 1] = alarm_event_i[g];
			assign alarm_set[3 * g + 2] = 1'b0;
		end
	endgenerate
	assign alarm_set[15:12] = {1'b0, loop_event_i, 2'b00};

	// A new event wins over a host clear in the same cycle
	assign alarm_d = ((alarm_q & ~alarm_wm) | (wr_val & alarm_wm) | alarm_set)
		& `LCSM_ALARM_WR_MASK & ~16'h1000;
	assign ext_d = (ext_q & ~ext_wm[12:0]) | (wr_val[12:0] & ext_wm[12:0])
		| ext_event_i;

	// One register per word keeps each process short and easy to follow
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= `LCSM_WORD_RST;
		end else begin
			mode_q <= mode_next;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			alarm_q <= `LCSM_WORD_RST;
		end else begin
			alarm_q <= alarm_d;
		end
	end

	// Not-acknowledged flags stay set until the host writes 0
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			ext_q <= 13'h0000;
		end else begin
			ext_q <= ext_d;
		end
	end

	// ----------------------------------------
	// Commands: tuning transfer and button presses
	// ----------------------------------------
	logic xfer_d;
	logic press1;
	logic press2;
	assign xfer_d = ext_wm[`LCSM_EXT_XFER_BIT] && wr_val[`LCSM_EXT_XFER_BIT];
	assign press1 = ext_wm[`LCSM_EXT_PB1_BIT] && wr_val[`LCSM_EXT_PB1_BIT];
	assign press2 = ext_wm[`LCSM_EXT_PB2_BIT] && wr_val[`LCSM_EXT_PB2_BIT];

	lcsm_pbsw u_pb1 (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b),
		.press_i(press1),
		.sustained_i(pb_sustained_i[0]),
		.scan_tick_i(scan_tick_i),
		.level_o(pushbutton_switch_one_o)
	);

	lcsm_pbsw u_pb2 (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b),
		.press_i(press2),
		.sustained_i(pb_sustained_i[1]),
		.scan_tick_i(scan_tick_i),
		.level_o(pushbutton_switch_two_o)
	);

	// ----------------------------------------
	// Read composition
	// ----------------------------------------
	lcsm_word_t mode_rd;
	lcsm_word_t alarm_rd;
	lcsm_word_t ext_rd;
	lcsm_word_t word_rd;
	lcsm_word_t rd_d;
	lcsm_word_t mode_ro;
	lcsm_word_t alarm_ro;

	// ----------------------------------------
	// Read-only status
	// ----------------------------------------
	// Owned by the function blocks; the host sees them but cannot change them
	assign mode_ro[1:0] = 2'b00;
	assign mode_ro[2] = standby_i;
	assign mode_ro[6:3] = 4'h0;
	assign mode_ro[7] = override_i;
	assign mode_ro[8] = emergency_manual_flag_i;
	assign mode_ro[9] = configuration_hold_flag_i;
	assign mode_ro[10] = high_setpoint_limit_flag_i;
	assign mode_ro[11] = low_setpoint_limit_flag_i;
	assign mode_ro[12] = 1'b0;
	assign mode_ro[13] = user_status_one_i;
	assign mode_ro[14] = user_status_two_i;
	assign mode_ro[15] = 1'b0;
	assign mode_rd = mode_q | mode_ro;

	// Active flags of alarms 1 to 4 land on every third bit
	generate
		for (g = 0; g < 4; g++) begin : g_alarm_ro
			assign alarm_ro[3 * g] = alarm_active_i[g];
			assign alarm_ro[3 * g + 1] = 1'b0;
			assign alarm_ro[3 * g + 2] = 1'b0;
		end
	endgenerate
	// Out of service reads from the single flag kept with the mode word
	assign alarm_ro[15:12] = {active_loop_event_i, 1'b0, configuration_changed_i,
		mode_q[`LCSM_OOS_BIT]};
	assign alarm_rd = alarm_q | alarm_ro;
	// Transfer bit is write-only and reads back zero
	assign ext_rd = {pushbutton_switch_two_o, pushbutton_switch_one_o, 1'b0,
		ext_q};
	function automatic lcsm_word_t pick_word(input lcsm_wsel_t s, input lcsm_word_t m,
		input lcsm_word_t a, input lcsm_word_t x);
		case (s)
			LCSM_W_MODE: pick_word = m;
			LCSM_W_ALARM: pick_word = a;
			LCSM_W_EXT: pick_word = x;
			default: pick_word = 16'h0000;
		endcase
	endfunction

	// Unmapped addresses read as zero as well as raising the error flag
	assign word_rd = pick_word(sel, mode_rd, alarm_rd, ext_rd);
	assign rd_d = req_coil_i ? {15'h0000, word_rd[coil_off[3:0]]} : word_rd;

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Response to the host, one cycle after every request
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			rsp_valid_o <= 1'b0;
			rsp_err_o <= 1'b0;
			rsp_rdata_o <= `LCSM_WORD_RST;
		end else begin
			rsp_valid_o <= req_i;
			rsp_err_o <= req_i && (sel == LCSM_W_NONE);
			rsp_rdata_o <= (req_i && !req_we_i) ? rd_d : 16'h0000;
		end
	end

	// Transfer is a one-cycle strobe; nothing of it is stored
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			tuning_parameter_transfer_o <= 1'b0;
		end else begin
			tuning_parameter_transfer_o <= xfer_d;
		end
	end

	// Mirrors of the storage, updated on the same edge so they never lag a write
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			mode_ctrl_o <= `LCSM_WORD_RST;
			alarm_ctrl_o <= `LCSM_WORD_RST;
			ext_unack_o <= 13'h0000;
		end else begin
			mode_ctrl_o <= mode_next;
			alarm_ctrl_o <= alarm_d;
			ext_unack_o <= ext_d;
		end
	end
endmodule // lcsm_loop_map

// file: verif/lcsm_loop_map_assertions.sv
// Port checker for the loop coil map
`timescale 1ns/1ns
`include "lcsm_cfg.svh"
module lcsm_loop_map_assertions #(
	parameter logic [15:0] LOOP_NUM = 16'h0001
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic req_i,
	input wire logic req_we_i,
	input wire logic req_coil_i,
	input wire logic [15:0] req_addr_i,
	input wire lcsm_pkg::lcsm_word_t req_wdata_i,
	input wire logic rsp_err_o,
	input wire logic [3:0] alarm_event_i,
	input wire logic loop_event_i,
	input wire logic [12:0] ext_event_i,
	input wire logic [1:0] pb_sustained_i,
	input wire logic scan_tick_i,
	input wire lcsm_pkg::lcsm_word_t mode_ctrl_o,
	input wire lcsm_pkg::lcsm_word_t alarm_ctrl_o,
	input wire logic [12:0] ext_unack_o,
	input wire logic tuning_parameter_transfer_o,
	input wire logic pushbutton_switch_one_o,
	input wire logic pushbutton_switch_two_o
);
	import lcsm_pkg::*;
	localparam logic [15:0] FIRST = 16'h0128 + 16'h0030 * (LOOP_NUM - 16'h0001);
	wire wr_w = req_i && req_we_i && !req_coil_i;
	wire wr_mode = wr_w && req_addr_i == `LCSM_ADDR_MODE;
	wire wr_alarm = wr_w && req_addr_i == `LCSM_ADDR_ALARM;
	wire wr_ext = wr_w && req_addr_i == `LCSM_ADDR_EXT;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	coil_low_err_a: assert property (req_i && req_coil_i && req_addr_i < FIRST
		|=> rsp_err_o) else $error("coil below block accepted");
	mode_write_a: assert property (wr_mode |=>
		mode_ctrl_o == ($past(req_wdata_i) & `LCSM_MODE_WR_MASK)) else $error("mode write");
	alarm_write_a: assert property (wr_alarm && alarm_event_i == 4'h0 && !loop_event_i |=>
		alarm_ctrl_o == ($past(req_wdata_i) & `LCSM_ALARM_WR_MASK & 16'hEFFF))
		else $error("alarm write");
	alarm_event_a: assert property ({loop_event_i, alarm_event_i} != 5'h00 |=>
		({alarm_ctrl_o[14], alarm_ctrl_o[10], alarm_ctrl_o[7], alarm_ctrl_o[4], alarm_ctrl_o[1]}
		& $past({loop_event_i, alarm_event_i})) == $past({loop_event_i, alarm_event_i}))
		else $error("alarm event lost");
	ext_event_a: assert property (ext_event_i != 13'h0000 |=>
		(ext_unack_o & $past(ext_event_i)) == $past(ext_event_i)) else $error("ext event lost");
	ext_ack_a: assert property (wr_ext && ext_event_i == 13'h0000 |=>
		ext_unack_o == $past(req_wdata_i[12:0])) else $error("ext write");
	xfer_pulse_a: assert property (wr_ext && req_wdata_i[13] |=>
		tuning_parameter_transfer_o ##1 !tuning_parameter_transfer_o) else $error("transfer pulse");
	pb_toggle_a: assert property (wr_ext && req_wdata_i[15] && pb_sustained_i[1] |=>
		pushbutton_switch_two_o != $past(pushbutton_switch_two_o)) else $error("no toggle");
	pb_scan_a: assert property (!$past(pb_sustained_i[0])
		&& $changed(pushbutton_switch_one_o) |-> $past(scan_tick_i))
		else $error("momentary off scan");
endmodule // lcsm_loop_map_assertions

// file: verif/lcsm_host_model.sv
// Network host model issuing single accesses
`timescale 1ns/1ns
module lcsm_host_model (
	input wire logic mclk_i,
	input wire logic valid_i,
	input wire logic err_i,
	input wire lcsm_pkg::lcsm_word_t rdata_i,
	output logic req_o,
	output logic we_o,
	output logic coil_o,
	output logic [15:0] addr_o,
	output lcsm_pkg::lcsm_word_t wdata_o
);
	import lcsm_pkg::*;
	initial {req_o, we_o, coil_o, addr_o, wdata_o} = '0;
	// Called just after a rising edge; the answer is taken one edge after the request edge
	task automatic xfer(input logic we, c, input logic [15:0] a, d,
		output logic v, e, output lcsm_word_t q);
		req_o <= 1'b1;
		we_o <= we;
		coil_o <= c;
		addr_o <= a;
		wdata_o <= d;
		@(posedge mclk_i);
		req_o <= 1'b0;
		@(posedge mclk_i);
		v = valid_i;
		e = err_i;
		q = rdata_i;
	endtask
endmodule // lcsm_host_model

// file: verif/lcsm_loop_map_bench.sv
// Self-checking bench for the loop coil map
`timescale 1ns/1ns
module lcsm_loop_map_bench;
	import lcsm_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic req_i, req_we_i, req_coil_i, rsp_valid_o, rsp_err_o, tuning_parameter_transfer_o;
	logic pushbutton_switch_one_o, pushbutton_switch_two_o, scan_tick_i, loop_event_i;
	logic standby_i, override_i, emergency_manual_flag_i, configuration_hold_flag_i;
	logic high_setpoint_limit_flag_i, low_setpoint_limit_flag_i;
	logic user_status_one_i, user_status_two_i, configuration_changed_i, active_loop_event_i;
	logic [15:0] req_addr_i;
	lcsm_word_t req_wdata_i, rsp_rdata_o, mode_ctrl_o, alarm_ctrl_o, q, ex;
	logic [3:0] alarm_active_i, alarm_event_i;
	logic [12:0] ext_event_i, ext_unack_o;
	logic [1:0] pb_sustained_i;
	logic e, v;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;

	lcsm_loop_map #(.LOOP_NUM(16'h0001)) i_lcsm_loop_map (.*);
	lcsm_host_model i_lcsm_host_model (.mclk_i(mclk_i), .valid_i(rsp_valid_o),
		.err_i(rsp_err_o), .rdata_i(rsp_rdata_o), .req_o(req_i), .we_o(req_we_i),
		.coil_o(req_coil_i), .addr_o(req_addr_i), .wdata_o(req_wdata_i));

	always #50 mclk_i = ~mclk_i;
	// Whole run needs about 100 cycles
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			conclude();
		end
	end

	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic chk(input lcsm_word_t got, exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic we, c, input logic [15:0] a, d);
		i_lcsm_host_model.xfer(we, c, a, d, v, e, q);
		chk({15'h0000, v}, 16'h0001);
	endtask
	task automatic rd(input logic c, input logic [15:0] a, exp);
		acc(1'b0, c, a, 16'h0000);
		chk({15'h0000, e}, 16'h0000);
		chk(q, exp);
	endtask
	task automatic err(input logic c, input logic [15:0] a);
		acc(1'b0, c, a, 16'h0000);
		chk({15'h0000, e}, 16'h0001);
	endtask
	task automatic tick();
		scan_tick_i <= 1'b1;
		@(posedge mclk_i);
		scan_tick_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		{standby_i, override_i, emergency_manual_flag_i, configuration_hold_flag_i,
			high_setpoint_limit_flag_i, low_setpoint_limit_flag_i, user_status_one_i,
			user_status_two_i} = 8'h00;
		{alarm_active_i, configuration_changed_i, active_loop_event_i} = 6'h00;
		{alarm_event_i, loop_event_i, ext_event_i, pb_sustained_i, scan_tick_i} = '0;
		repeat (5) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		acc(1'b1, 1'b0, 16'h0301, 16'hFFFF);
		rd(1'b0, 16'h0301, 16'h907B);
		chk(mode_ctrl_o, 16'h907B);
		{standby_i, override_i, emergency_manual_flag_i, configuration_hold_flag_i,
			high_setpoint_limit_flag_i, low_setpoint_limit_flag_i, user_status_one_i,
			user_status_two_i} <= 8'hFF;
		acc(1'b1, 1'b0, 16'h0301, 16'hA5A5);
		ex = 16'hEFA5;
		rd(1'b0, 16'h0301, ex);
		for (int i = 0; i < 16; i++) begin
			rd(1'b1, 16'h0128 + i[15:0], {15'h0000, ex[i]});
		end
		err(1'b1, 16'h0127);
		err(1'b1, 16'h0158);
		err(1'b0, 16'h0302);
		acc(1'b1, 1'b1, 16'h0128, 16'h0000);
		acc(1'b1, 1'b1, 16'h012A, 16'h0000);
		rd(1'b0, 16'h0301, 16'hEFA4);
		$display("test mode and coils finished");
		{alarm_active_i, configuration_changed_i, active_loop_event_i} <= 6'h3F;
		acc(1'b1, 1'b0, 16'h0401, 16'hFFFF);
		rd(1'b0, 16'h0401, 16'hFFFF);
		acc(1'b1, 1'b0, 16'h0401, 16'h0000);
		rd(1'b0, 16'h0401, 16'hA249);
		{alarm_active_i, configuration_changed_i, active_loop_event_i} <= 6'h00;
		{alarm_event_i, loop_event_i} <= 5'h1F;
		@(posedge mclk_i);
		{alarm_event_i, loop_event_i} <= 5'h00;
		@(posedge mclk_i);
		rd(1'b0, 16'h0401, 16'h4492);
		$display("test alarm word finished");
		ext_event_i <= 13'h1FFF;
		@(posedge mclk_i);
		ext_event_i <= 13'h0000;
		@(posedge mclk_i);
		rd(1'b0, 16'h040A, 16'h1FFF);
		acc(1'b1, 1'b0, 16'h040A, 16'h2000);
		rd(1'b0, 16'h040A, 16'h0000);
		pb_sustained_i <= 2'b10;
		acc(1'b1, 1'b0, 16'h040A, 16'h8000);
		rd(1'b0, 16'h040A, 16'h8000);
		acc(1'b1, 1'b0, 16'h040A, 16'h8000);
		rd(1'b0, 16'h040A, 16'h0000);
		acc(1'b1, 1'b1, 16'h0156, 16'h0001);
		rd(1'b0, 16'h040A, 16'h0000);
		tick();
		rd(1'b0, 16'h040A, 16'h4000);
		tick();
		rd(1'b0, 16'h040A, 16'h0000);
		$display("test extended word finished");
		conclude();
	end
endmodule // lcsm_loop_map_bench

bind lcsm_loop_map lcsm_loop_map_assertions #(.LOOP_NUM(LOOP_NUM)) i_lcsm_loop_map_assertions (.*);
